/* design/host_port.sv */
// Host port: Motorola-style parallel mode and serial mode front end
//
// Behaviour
// - Ready high times are counted from the master clock period of 12.86 ns, converted to local clock cycles.
// - On a parallel read, valid data is driven on the shared bus within six local clock cycles of select, not 3.5 master periods plus 10 ns.
// - The shared bus is released once chip select rises at the end of a parallel read.
// - Ready is driven when chip select falls and released after chip select rises on every parallel access.
// - On a parallel read ready stays high at least 4.5 master periods plus 10 ns, and the host waits for it to fall.
// - Parallel write data is captured at the rising edge of chip select while the host holds it steady.
// - With the edge select low, serial read bits change on the rising serial clock edge.
// - With the edge select high, serial read bits change on the falling serial clock edge.
// - During a serial write the data input is sampled on each rising serial clock edge.
// - The serial data output is released once chip select rises at the end of a serial read.
`timescale 1ns/1ps
module host_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic serial_mode,
  input wire logic cs_n,
  input wire logic rw,
  input wire logic [host_port_pkg::AD_W-1:0] ad_in,
  output logic [host_port_pkg::AD_W-1:0] ad_out,
  output logic ad_oe_n,
  output logic rdy_out,
  output logic rdy_oe_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic sdo_oe_n,
  input wire logic output_edge_select,
  output host_port_pkg::reg_req_t reg_req,
  input wire logic [host_port_pkg::AD_W-1:0] rdata
);
  import host_port_pkg::*;

  logic [PIN_W-1:0] pins;
  logic cs_prev_reg;
  logic sclk_prev_reg;
  logic mode_s;
  logic cs_s;
  logic rw_s;
  logic [AD_W-1:0] ad_s;
  logic sclk_s;
  logic sdi_s;
  logic edge_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic ser_active;

  par_state_t par_state_reg;
  logic par_read_reg;
  logic [CNT_W-1:0] rdy_cnt_reg;
  logic par_take;
  logic par_end;

  logic [BITCNT_W-1:0] bitcnt_reg;
  logic [AD_W-2:0] sin_reg;
  logic ser_write_reg;
  logic ser_read_reg;
  logic load_pending_reg;
  logic [AD_W-1:0] sdo_sh_reg;
  logic hdr_done;
  logic wr_done;
  logic out_shift;

  pin_sync3 #(
    .W(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({serial_mode, cs_n, rw, ad_in, sclk, serial_data_in, output_edge_select}),
    .q(pins)
  );

  assign mode_s = pins[PIN_MODE];
  assign cs_s = pins[PIN_CS];
  assign rw_s = pins[PIN_RW];
  assign ad_s = pins[PIN_AD_LSB +: AD_W];
  assign sclk_s = pins[PIN_SCLK];
  assign sdi_s = pins[PIN_SDI];
  assign edge_s = pins[PIN_EDGE];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      cs_prev_reg <= cs_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  assign cs_fall = cs_prev_reg & ~cs_s;
  assign cs_rise = ~cs_prev_reg & cs_s;
  assign ser_active = mode_s & ~cs_s;
  assign sclk_rise = ser_active & ~sclk_prev_reg & sclk_s;
  assign sclk_fall = ser_active & sclk_prev_reg & ~sclk_s;

  assign par_take = cs_fall & ~mode_s & (par_state_reg == P_IDLE);
  assign par_end = cs_rise & (par_state_reg != P_IDLE);

  // Parallel access sequencer: bus drive and ready handshake
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      par_state_reg <= P_IDLE;
      par_read_reg <= 1'b0;
      rdy_cnt_reg <= '0;
      ad_out <= '0;
      ad_oe_n <= 1'b1;
      rdy_out <= 1'b0;
      rdy_oe_n <= 1'b1;
    end
    else if (par_end)
    begin
      // Chip select rise ends any access, even one cut short
      par_state_reg <= P_IDLE;
      ad_oe_n <= 1'b1;
      rdy_out <= 1'b0;
      rdy_oe_n <= 1'b1;
    end
    else
    begin
      case (par_state_reg)
        P_IDLE:
        begin
          if (par_take)
          begin
            par_read_reg <= rw_s;
            rdy_out <= 1'b0;
            rdy_oe_n <= 1'b0;
            par_state_reg <= P_FETCH;
          end
        end
        P_FETCH:
        begin
          // Read data is sampled one cycle after the address is presented
          if (par_read_reg)
          begin
            ad_out <= rdata;
            ad_oe_n <= 1'b0;
            rdy_cnt_reg <= CNT_W'(RDY_RD_CYC - 1);
          end
          else
          begin
            rdy_cnt_reg <= CNT_W'(RDY_WR_CYC - 1);
          end
          rdy_out <= 1'b1;
          par_state_reg <= P_HIGH;
        end
        P_HIGH:
        begin
          if (rdy_cnt_reg == '0)
          begin
            rdy_out <= 1'b0;
            par_state_reg <= P_LOW;
          end
          else
          begin
            rdy_cnt_reg <= rdy_cnt_reg - 1'b1;
          end
        end
        P_LOW:
        begin
          par_state_reg <= P_LOW;
        end
        default:
        begin
          par_state_reg <= P_IDLE;
        end
      endcase
    end
  end

  // Serial frame: one direction bit (high reads), seven address bits, eight data bits
  assign hdr_done = sclk_rise & (bitcnt_reg == SER_HDR_LAST);
  assign wr_done = sclk_rise & ser_write_reg & (bitcnt_reg == SER_FRAME_LAST);
  assign out_shift = ser_read_reg & ~load_pending_reg &
    ((~edge_s & sclk_rise & (bitcnt_reg >= SER_OUT_RISE_FIRST) & (bitcnt_reg < SER_FRAME_LAST)) |
     (edge_s & sclk_fall & (bitcnt_reg >= SER_OUT_FALL_FIRST)));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitcnt_reg <= '0;
      sin_reg <= '0;
      ser_write_reg <= 1'b0;
      ser_read_reg <= 1'b0;
    end
    else if (cs_fall)
    begin
      bitcnt_reg <= '0;
      ser_write_reg <= 1'b0;
      ser_read_reg <= 1'b0;
    end
    else if (sclk_rise)
    begin
      sin_reg <= {sin_reg[AD_W-3:0], sdi_s};
      // Extra clocks past the frame are ignored
      if (bitcnt_reg != SER_FRAME_LEN)
        bitcnt_reg <= bitcnt_reg + 1'b1;
      if (hdr_done)
      begin
        ser_read_reg <= sin_reg[AD_W-2];
        ser_write_reg <= ~sin_reg[AD_W-2];
      end
    end
  end

  // Serial output shifter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      load_pending_reg <= 1'b0;
      sdo_sh_reg <= '0;
      serial_data_out <= 1'b0;
      sdo_oe_n <= 1'b1;
    end
    else if (cs_rise)
    begin
      load_pending_reg <= 1'b0;
      sdo_oe_n <= 1'b1;
    end
    else if (hdr_done & sin_reg[AD_W-2])
    begin
      load_pending_reg <= 1'b1;
    end
    else if (load_pending_reg)
    begin
      // First bit goes out early; the slow serial clock leaves ample margin
      load_pending_reg <= 1'b0;
      sdo_sh_reg <= rdata;
      serial_data_out <= rdata[AD_W-1];
      sdo_oe_n <= 1'b0;
    end
    else if (out_shift)
    begin
      sdo_sh_reg <= {sdo_sh_reg[AD_W-2:0], 1'b0};
      serial_data_out <= sdo_sh_reg[AD_W-2];
    end
  end

  // Register-side strobes; rdata must follow addr combinationally
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_req <= '0;
    end
    else
    begin
      reg_req.rd <= 1'b0;
      reg_req.wr <= 1'b0;
      if (par_take)
      begin
        reg_req.addr <= ad_s;
        reg_req.rd <= rw_s;
      end
      else if (par_end & ~par_read_reg)
      begin
        reg_req.wdata <= ad_s;
        reg_req.wr <= 1'b1;
      end
      else if (hdr_done)
      begin
        reg_req.addr <= {1'b0, sin_reg[AD_W-3:0], sdi_s};
        reg_req.rd <= sin_reg[AD_W-2];
      end
      else if (wr_done)
      begin
        reg_req.wdata <= {sin_reg, sdi_s};
        reg_req.wr <= 1'b1;
      end
    end
  end
endmodule // host_port

/* design/host_port_pkg.sv */
// Shared constants, timing counts and types for the host port
package host_port_pkg;
  localparam int unsigned CLK_PERIOD_PS = 20000;
  localparam int unsigned MASTER_PERIOD_PS = 12860;
  // Ready high time on a read is 4.5 master periods plus 10 ns
  localparam int unsigned RDY_RD_HIGH_PS = (9 * MASTER_PERIOD_PS) / 2 + 10000;
  // Ready high time on a write is 1.5 master periods plus 10 ns
  localparam int unsigned RDY_WR_HIGH_PS = (3 * MASTER_PERIOD_PS) / 2 + 10000;
  localparam int unsigned RDY_RD_CYC = (RDY_RD_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RDY_WR_CYC = (RDY_WR_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 3;

  localparam int unsigned AD_W = 8;
  localparam int unsigned BITCNT_W = 5;
  localparam logic [BITCNT_W-1:0] SER_HDR_LAST = 5'h07;
  localparam logic [BITCNT_W-1:0] SER_FRAME_LAST = 5'h0f;
  localparam logic [BITCNT_W-1:0] SER_FRAME_LEN = 5'h10;
  localparam logic [BITCNT_W-1:0] SER_OUT_RISE_FIRST = 5'h08;
  localparam logic [BITCNT_W-1:0] SER_OUT_FALL_FIRST = 5'h09;

  // Packing of the synchronised pin vector
  localparam int unsigned PIN_W = 14;
  localparam int unsigned PIN_MODE = 13;
  localparam int unsigned PIN_CS = 12;
  localparam int unsigned PIN_RW = 11;
  localparam int unsigned PIN_AD_LSB = 3;
  localparam int unsigned PIN_SCLK = 2;
  localparam int unsigned PIN_SDI = 1;
  localparam int unsigned PIN_EDGE = 0;
  // Chip select idles high, everything else low
  localparam logic [PIN_W-1:0] PIN_RST = 14'h1000;

  typedef struct packed {
    logic [AD_W-1:0] addr;
    logic [AD_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum {P_IDLE, P_FETCH, P_HIGH, P_LOW} par_state_t;
endpackage

/* design/pin_sync3.sv */
// Three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Per bit: follow stage three only where stages two and three agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      q <= RST_VAL;
    else
      q <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q);
  end
endmodule // pin_sync3

/* tb/host_model.sv */
// Host processor model driving the port pins
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic serial_mode,
  output logic cs_n,
  output logic rw,
  output logic [7:0] ad_in,
  output logic sclk,
  output logic serial_data_in,
  output logic output_edge_select,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic rdy_out,
  input wire logic serial_data_out,
  input wire logic sdo_oe_n
);
  logic [7:0] drv;
  int stalls;
  // Bus wire: device wins while it drives, else the host value
  assign ad_in = ad_oe_n ? drv : ad_out;
  initial
  begin
    serial_mode = 0;
    cs_n = 1;
    rw = 1;
    drv = 8'h00;
    stalls = 0;
    sclk = 0;
    serial_data_in = 0;
    output_edge_select = 0;
  end
  task automatic par(input logic r, input logic [7:0] a, d, output logic [7:0] q);
    int n;
    @(posedge clk);
    #2 rw = r;
    drv = a;
    cs_n = 0;
    // Outputs are looked at on the falling clock edge, where they have settled
    for (n = 0; n < 20 && rdy_out !== 1'b1; n++) @(negedge clk);
    if (n == 20) stalls++;
    q = ad_in;
    @(posedge clk);
    // Inverse pattern on a read so a stale bus never passes for data
    #2 drv = r ? ~a : d;
    for (n = 0; n < 20 && rdy_out !== 1'b0; n++) @(negedge clk);
    if (n == 20) stalls++;
    @(posedge clk);
    #2 cs_n = 1;
    repeat (2) @(posedge clk);
    #2 drv = ~drv;
    repeat (8) @(posedge clk);
  endtask
  task automatic ser(input logic e, input logic [15:0] f, output logic [7:0] q);
    int m;
    q = 8'h00;
    @(posedge clk);
    #2 serial_mode = 1;
    output_edge_select = e;
    repeat (6) @(posedge clk);
    #2 cs_n = 0;
    for (m = 1; m <= 16; m++)
    begin
      serial_data_in = f[16-m];
      // Just before each rise the falling-edge choice still shows the bit before
      // A released output reads as the inverse of its last value
      #79 if (m > 8 + e) q[16-m+e] = sdo_oe_n ? ~serial_data_out : serial_data_out;
      #1 sclk = 1;
      #80 sclk = 0;
    end
    #40 cs_n = 1;
    repeat (10) @(posedge clk);
    #2 serial_mode = 0;
    repeat (6) @(posedge clk);
  endtask
endmodule // host_model

/* tb/host_port_properties.sv */
// Pin-level checks of the host port
`timescale 1ns/1ps
module host_port_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic serial_mode,
  input wire logic cs_n,
  input wire logic rw,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic rdy_out,
  input wire logic rdy_oe_n,
  input wire logic serial_data_out,
  input wire logic sdo_oe_n,
  input wire logic [7:0] rdata,
  input host_port_pkg::reg_req_t reg_req
);
  import host_port_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_ready;
    rdy_out [*4] ##1 !rdy_out;
  endsequence
  sequence wr_ready;
    rdy_out [*2] ##1 !rdy_out;
  endsequence
  rd_ready_width_a: assert property ($fell(rdy_oe_n) && rw && !serial_mode |=> rd_ready)
    else $error("read ready width wrong");
  wr_ready_width_a: assert property ($fell(rdy_oe_n) && !rw && !serial_mode |=> wr_ready)
    else $error("write ready width wrong");
  rd_data_a: assert property (reg_req.rd && !serial_mode |=> !ad_oe_n && ad_out == $past(rdata))
    else $error("read data not driven");
  rd_latency_a: assert property ($fell(cs_n) && rw && !serial_mode |-> ##[4:8] !ad_oe_n)
    else $error("read data late");
  par_release_a: assert property ($rose(cs_n) && !serial_mode |-> ##[2:8] ad_oe_n && rdy_oe_n)
    else $error("bus or ready not released");
  rdy_drive_a: assert property ((!cs_n && !serial_mode) [*7] |-> !rdy_oe_n)
    else $error("ready not driven");
  wr_capture_a: assert property ($rose(cs_n) && !rw && !serial_mode |-> ##[2:8] reg_req.wr)
    else $error("write not issued");
  sdo_first_a: assert property (reg_req.rd && serial_mode |=> !sdo_oe_n && serial_data_out == $past(rdata[7]))
    else $error("first serial bit wrong");
  sdo_release_a: assert property ($rose(cs_n) && serial_mode |-> ##[2:8] sdo_oe_n)
    else $error("serial out not released");
endmodule // host_port_properties

/* tb/host_port_tb_top.sv */
// Testbench for the host port
`timescale 1ns/1ps
module host_port_tb_top;
  import host_port_pkg::*;
  logic clk, nrst, serial_mode, cs_n, rw, sclk, serial_data_in, output_edge_select;
  logic ad_oe_n, rdy_out, rdy_oe_n, serial_data_out, sdo_oe_n;
  logic [7:0] ad_in, ad_out, rdata, q, wa, wd, wn, a, d, x, k;
  reg_req_t reg_req;
  int mismatches, check_count, cyc;
  host_port DUT (.clk, .nrst, .serial_mode, .cs_n, .rw, .ad_in, .ad_out, .ad_oe_n, .rdy_out, .rdy_oe_n,
    .sclk, .serial_data_in, .serial_data_out, .sdo_oe_n, .output_edge_select, .reg_req, .rdata);
  host_model host (.clk, .serial_mode, .cs_n, .rw, .ad_in, .sclk, .serial_data_in, .output_edge_select,
    .ad_out, .ad_oe_n, .rdy_out, .serial_data_out, .sdo_oe_n);
  function automatic logic [7:0] fn(input logic [7:0] v);
    return {v[3:0], ~v[7:4]};
  endfunction
  assign rdata = fn(reg_req.addr);
  // Register-side write log: last address, last data and number of writes
  always @(posedge clk or negedge nrst)
    if (!nrst)
      wn <= 8'h00;
    else if (reg_req.wr === 1'b1)
    begin
      wa <= reg_req.addr;
      wd <= reg_req.wdata;
      wn <= wn + 8'h01;
    end
  task automatic chk(input string s, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_of_test;
    end
  end
  initial
  begin
    nrst = 0;
    a = 8'($urandom(22));
    repeat (6) @(posedge clk);
    #2 nrst = 1;
    for (int i = 0; i < 8; i++)
    begin
      a = (i < 2) ? {8{i[0]}} : 8'($urandom);
      d = 8'($urandom);
      host.par(0, a, d, q);
      chk("par_wr_count", wn, 8'(2 * i + 1));
      chk("par_wr_addr", wa, a);
      chk("par_wr_data", wd, d);
      host.par(1, a, 8'h00, q);
      chk("par_rd", q, fn(a));
      host.ser(i[0], {1'b0, a[6:0], ~d}, q);
      chk("ser_wr_count", wn, 8'(2 * i + 2));
      chk("ser_wr_addr", wa, {1'b0, a[6:0]});
      chk("ser_wr_data", wd, ~d);
      host.ser(i[0], {1'b1, a[6:0], 8'h00}, q);
      x = fn({1'b0, a[6:0]});
      k = i[0] ? 8'hfe : 8'hff;
      chk("ser_rd", q & k, x & k);
    end
    chk("handshake_stalls", 8'(host.stalls), 8'h00);
    end_of_test;
  end
endmodule // host_port_tb_top
bind host_port host_port_properties chk_i (.clk, .nrst, .serial_mode, .cs_n, .rw, .ad_out, .ad_oe_n, .rdy_out,
  .rdy_oe_n, .serial_data_out, .sdo_oe_n, .rdata, .reg_req);
